// [hw/sebs_defines.vh]
// Purpose: constants of the servo enable / brake sequencer
// Assumes: 50 MHz mclk, 32-bit classic wishbone register bus
// Notes: definitions only
`ifndef SEBS_DEFINES_VH
`define SEBS_DEFINES_VH

// ----------------------------------------------------------------
// timing and stop speed
// ----------------------------------------------------------------
`define SEBS_CLK_NS 20
`define SEBS_MS_NS 1000000
`define SEBS_MS_CYCLES (`SEBS_MS_NS / `SEBS_CLK_NS)
`define SEBS_DB_SETTLE_MS 16'h0002
`define SEBS_STOP_RPM 16'h001e

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SEBS_CTRL_OFS 8'h00
`define SEBS_PU_WAIT_OFS 8'h04
`define SEBS_STALL_DLY_OFS 8'h08
`define SEBS_RUN_DLY_OFS 8'h0c
`define SEBS_BRK_SPD_OFS 8'h10
`define SEBS_SEQ_OFS 8'h14
`define SEBS_STATUS_OFS 8'h18
`define SEBS_MFR_BASE 8'h80

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SEBS_CTRL_SON_BIT 0
`define SEBS_CTRL_BRK_BIT 1
`define SEBS_SEQ_OFF_DB_BIT 0
`define SEBS_SEQ_OFF_ENERG_BIT 1
`define SEBS_SEQ_ALM_DB_BIT 2
`define SEBS_ST_READY_BIT 0
`define SEBS_ST_PROT_BIT 1
`define SEBS_ST_ENERG_BIT 2
`define SEBS_ST_DB_BIT 3
`define SEBS_ST_BRK_BIT 4
`define SEBS_ST_TRAVEL_BIT 5
`define SEBS_ST_STATE_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SEBS_PU_WAIT_RST 16'h05dc
`define SEBS_STALL_DLY_RST 16'h0000
`define SEBS_RUN_DLY_RST 16'h0000
`define SEBS_BRK_SPD_RST 16'h001e
`define SEBS_SEQ_RST 3'h0

`endif

// [hw/sebs_sequencer.v]
// Purpose: servo ready, servo-on/off and brake sequencing of a servo drive
// Assumes: motor_speed is an absolute r/min value from logic on mclk
// Notes: registers on classic wishbone; status pins on mclk flip-flops
//
// Operation
// - servo ready needs init done, main power, no alarm, synced fieldbus link
// - protection, travel inhibit included, activates about 1.5 s after init starts
// - power-up protection delay is the wait-time register reset value, loaded at reset release
// - brake release output follows only the host brake release request
// - servo-off at standstill keeps motor energized for the stall delay
// - servo-off sequence setting selects dynamic brake engagement during deceleration after a running servo-off
// - servo-on withheld while motor speed is 30 r/min or more
// - running brake delay ends at delay expiry or speed below release speed
// - servo-on during deceleration waits until the motor has stopped
// - servo-off sequence setting selects energization during the running brake delay
// - alarm sequence setting selects dynamic brake behaviour when an alarm stops a running motor after protection activates
// - manufacturer parameter class is not reachable over the bus
`timescale 1ns/1ps
`default_nettype none
`include "sebs_defines.vh"

module sebs_sequencer #(
	parameter MS_CYCLES = `SEBS_MS_CYCLES
) (
	input wire mclk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire init_done,
	input wire main_power_ok,
	input wire alarm,
	input wire link_synced,
	input wire positive_travel_inhibit,
	input wire negative_travel_inhibit,
	input wire [15:0] motor_speed,
	output reg servo_ready_reg,
	output reg protect_active_reg,
	output reg travel_stop_reg,
	output reg dyn_brake_engaged_reg,
	output reg motor_energized_reg,
	output reg brake_release_output_reg
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam S_OFF = 3'h0;
localparam S_DB_REL = 3'h1;
localparam S_ON = 3'h2;
localparam S_STALL_OFF = 3'h3;
localparam S_RUN_OFF = 3'h4;
localparam S_DECEL = 3'h5;

function [15:0] lane_write;
	input [15:0] old;
	input [31:0] dat;
	input [3:0] sel;
	begin
		lane_write[7:0] = sel[0] ? dat[7:0] : old[7:0];
		lane_write[15:8] = sel[1] ? dat[15:8] : old[15:8];
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [5:0] meta_reg;
reg [5:0] sync_reg;
wire init_s = sync_reg[0];
wire power_s = sync_reg[1];
wire alarm_s = sync_reg[2];
wire link_s = sync_reg[3];
wire pos_inh_s = sync_reg[4];
wire neg_inh_s = sync_reg[5];

always @(posedge mclk) begin
	if (reset) begin
		meta_reg <= 6'h00;
		sync_reg <= 6'h00;
	end else begin
		meta_reg <= {negative_travel_inhibit, positive_travel_inhibit, link_synced,
			alarm, main_power_ok, init_done};
		sync_reg <= meta_reg;
	end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg son_cmd_reg;
reg brk_req_reg;
reg [15:0] pu_wait_reg;
reg [15:0] stall_dly_reg;
reg [15:0] run_dly_reg;
reg [15:0] brk_spd_reg;
reg [2:0] seq_reg;
reg [2:0] state_reg;
reg [2:0] state_next;

wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wr = req && wb_we_i;
wire mfr_area = wb_adr_i >= `SEBS_MFR_BASE;

always @(posedge mclk) begin
	if (reset) begin
		son_cmd_reg <= 1'b0;
		brk_req_reg <= 1'b0;
		pu_wait_reg <= `SEBS_PU_WAIT_RST;
		stall_dly_reg <= `SEBS_STALL_DLY_RST;
		run_dly_reg <= `SEBS_RUN_DLY_RST;
		brk_spd_reg <= `SEBS_BRK_SPD_RST;
		seq_reg <= `SEBS_SEQ_RST;
	end else if (wr && !mfr_area && wb_sel_i[0]) begin
		case (wb_adr_i)
		`SEBS_CTRL_OFS: begin
			son_cmd_reg <= wb_dat_i[`SEBS_CTRL_SON_BIT];
			brk_req_reg <= wb_dat_i[`SEBS_CTRL_BRK_BIT];
		end
		`SEBS_PU_WAIT_OFS: pu_wait_reg <= lane_write(pu_wait_reg, wb_dat_i, wb_sel_i);
		`SEBS_STALL_DLY_OFS: stall_dly_reg <= lane_write(stall_dly_reg, wb_dat_i, wb_sel_i);
		`SEBS_RUN_DLY_OFS: run_dly_reg <= lane_write(run_dly_reg, wb_dat_i, wb_sel_i);
		`SEBS_BRK_SPD_OFS: brk_spd_reg <= lane_write(brk_spd_reg, wb_dat_i, wb_sel_i);
		`SEBS_SEQ_OFS: seq_reg <= wb_dat_i[2:0];
		default: ;
		endcase
	end
end

// unmapped and manufacturer addresses are acked with zero, never an error
always @(posedge mclk) begin
	if (reset) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
	end else begin
		wb_ack_o <= req;
		wb_dat_o <= 32'h00000000;
		if (req && !wb_we_i && !mfr_area) begin
			case (wb_adr_i)
			`SEBS_CTRL_OFS: wb_dat_o <= {30'h00000000, brk_req_reg, son_cmd_reg};
			`SEBS_PU_WAIT_OFS: wb_dat_o <= {16'h0000, pu_wait_reg};
			`SEBS_STALL_DLY_OFS: wb_dat_o <= {16'h0000, stall_dly_reg};
			`SEBS_RUN_DLY_OFS: wb_dat_o <= {16'h0000, run_dly_reg};
			`SEBS_BRK_SPD_OFS: wb_dat_o <= {16'h0000, brk_spd_reg};
			`SEBS_SEQ_OFS: wb_dat_o <= {29'h00000000, seq_reg};
			`SEBS_STATUS_OFS: wb_dat_o <= {21'h000000, state_reg, 2'h0,
				travel_stop_reg, brake_release_output_reg, dyn_brake_engaged_reg,
				motor_energized_reg, protect_active_reg, servo_ready_reg};
			default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// millisecond tick and timers
// ----------------------------------------------------------------
reg [15:0] pre_reg;
reg ms_tick_reg;

always @(posedge mclk) begin
	if (reset) begin
		pre_reg <= 16'h0000;
		ms_tick_reg <= 1'b0;
	end else if (pre_reg == MS_CYCLES[15:0] - 16'h0001) begin
		pre_reg <= 16'h0000;
		ms_tick_reg <= 1'b1;
	end else begin
		pre_reg <= pre_reg + 16'h0001;
		ms_tick_reg <= 1'b0;
	end
end

// init starts at reset release; the wait is counted from then
reg pu_start_reg;
wire pu_done;

always @(posedge mclk) begin
	if (reset)
		pu_start_reg <= 1'b1;
	else
		pu_start_reg <= 1'b0;
end

sebs_timer #(.W(16)) u_pu_timer (
	.mclk(mclk),
	.reset(reset),
	.start(pu_start_reg),
	.tick(ms_tick_reg),
	.load_ms(pu_wait_reg),
	.done(pu_done)
);

reg dly_start;
reg [15:0] dly_load;
wire dly_done;

sebs_timer #(.W(16)) u_dly_timer (
	.mclk(mclk),
	.reset(reset),
	.start(dly_start),
	.tick(ms_tick_reg),
	.load_ms(dly_load),
	.done(dly_done)
);

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
wire stopped = motor_speed < `SEBS_STOP_RPM;
wire ready_now = init_s && power_s && !alarm_s && link_s;
wire alarm_hit = alarm_s && protect_active_reg;
reg alm_off_reg;

always @* begin
	state_next = state_reg;
	dly_start = 1'b0;
	dly_load = 16'h0000;
	case (state_reg)
	S_OFF: begin
		if (son_cmd_reg && servo_ready_reg && stopped) begin
			state_next = S_DB_REL;
			dly_start = 1'b1;
			dly_load = `SEBS_DB_SETTLE_MS;
		end
	end
	S_DB_REL: begin
		if (!son_cmd_reg || !servo_ready_reg)
			state_next = S_OFF;
		else if (dly_done)
			state_next = S_ON;
	end
	S_ON: begin
		if (alarm_hit || !son_cmd_reg || !servo_ready_reg) begin
			dly_start = 1'b1;
			if (stopped) begin
				state_next = S_STALL_OFF;
				dly_load = stall_dly_reg;
			end else begin
				state_next = S_RUN_OFF;
				dly_load = run_dly_reg;
			end
		end
	end
	S_STALL_OFF: begin
		if (dly_done)
			state_next = S_OFF;
	end
	S_RUN_OFF: begin
		if (dly_done || motor_speed < brk_spd_reg)
			state_next = S_DECEL;
	end
	S_DECEL: begin
		if (stopped)
			state_next = S_OFF;
	end
	default: state_next = S_OFF;
	endcase
end

// a running stop must not be cut short by a new servo-on
always @(posedge mclk) begin
	if (reset) begin
		state_reg <= S_OFF;
		alm_off_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		if (state_reg == S_ON && state_next != S_ON)
			alm_off_reg <= alarm_hit;
		else if (state_next == S_OFF && !alarm_hit)
			alm_off_reg <= 1'b0;
		else if (state_reg == S_OFF && alarm_hit)
			alm_off_reg <= 1'b1;
	end
end

// seq bit set means dynamic brake engaged in that phase
wire db_off_sel = alm_off_reg ? seq_reg[`SEBS_SEQ_ALM_DB_BIT] : seq_reg[`SEBS_SEQ_OFF_DB_BIT];

always @(posedge mclk) begin
	if (reset) begin
		servo_ready_reg <= 1'b0;
		protect_active_reg <= 1'b0;
		travel_stop_reg <= 1'b0;
		dyn_brake_engaged_reg <= 1'b1;
		motor_energized_reg <= 1'b0;
		brake_release_output_reg <= 1'b0;
	end else begin
		servo_ready_reg <= ready_now;
		if (pu_done)
			protect_active_reg <= 1'b1;
		travel_stop_reg <= protect_active_reg && (pos_inh_s || neg_inh_s);
		brake_release_output_reg <= brk_req_reg;
		case (state_next)
		S_OFF: begin
			motor_energized_reg <= 1'b0;
			dyn_brake_engaged_reg <= 1'b1;
		end
		S_DB_REL: begin
			dyn_brake_engaged_reg <= 1'b0;
			motor_energized_reg <= 1'b0;
		end
		S_ON: begin
			dyn_brake_engaged_reg <= 1'b0;
			motor_energized_reg <= 1'b1;
		end
		S_STALL_OFF: begin
			motor_energized_reg <= 1'b1;
			dyn_brake_engaged_reg <= 1'b0;
		end
		S_RUN_OFF, S_DECEL: begin
			motor_energized_reg <= (state_next == S_RUN_OFF) && !alm_off_reg && !alarm_hit &&
				seq_reg[`SEBS_SEQ_OFF_ENERG_BIT];
			if (alarm_hit || alm_off_reg)
				dyn_brake_engaged_reg <= seq_reg[`SEBS_SEQ_ALM_DB_BIT];
			else
				dyn_brake_engaged_reg <= db_off_sel;
		end
		default: begin
			motor_energized_reg <= 1'b0;
			dyn_brake_engaged_reg <= 1'b1;
		end
		endcase
	end
end

endmodule // sebs_sequencer

`default_nettype wire

// [hw/sebs_timer.v]
// Purpose: millisecond down-counter used for sequencer delays
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes: done stays high from expiry until the next start
`timescale 1ns/1ps
`default_nettype none

module sebs_timer #(
	parameter W = 16
) (
	input wire mclk,
	input wire reset,
	input wire start,
	input wire tick,
	input wire [W-1:0] load_ms,
	output wire done
);

reg [W-1:0] count_reg;
reg run_reg;

assign done = run_reg && (count_reg == {W{1'b0}});

always @(posedge mclk) begin
	if (reset) begin
		count_reg <= {W{1'b0}};
		run_reg <= 1'b0;
	end else if (start) begin
		count_reg <= load_ms;
		run_reg <= 1'b1;
	end else if (tick && run_reg && count_reg != {W{1'b0}}) begin
		count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
	end
end

endmodule // sebs_timer

`default_nettype wire

// [test/sebs_host_model.sv]
// Purpose: fieldbus host model issuing register commands
// Assumes: classic wishbone, slave answers in its own time
// Notes: the bench calls xfer by hierarchical name
`timescale 1ns/1ps
`default_nettype none
module sebs_host_model (
	input wire logic mclk,
	output logic wb_cyc_i = 1'b0,
	output logic wb_stb_i = 1'b0,
	output logic wb_we_i = 1'b0,
	output logic [7:0] wb_adr_i = 8'h00,
	output logic [3:0] wb_sel_i = 4'h0,
	output logic [31:0] wb_dat_i = 32'h0,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		// released data must not look valid
		wb_dat_i <= ~d;
		@(posedge mclk);
	endtask
endmodule // sebs_host_model
`default_nettype wire

// [test/sebs_sequencer_chk.sv]
// Purpose: port checks of the servo enable and brake sequencer
// Assumes: bound to every sebs_sequencer instance
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
module sebs_chk (
	input wire mclk,
	input wire reset,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire init_done,
	input wire main_power_ok,
	input wire alarm,
	input wire link_synced,
	input wire [15:0] motor_speed,
	input wire servo_ready_reg,
	input wire protect_active_reg,
	input wire travel_stop_reg,
	input wire dyn_brake_engaged_reg,
	input wire motor_energized_reg,
	input wire brake_release_output_reg
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_ready;
		servo_ready_reg |-> $past(init_done, 3) && $past(main_power_ok, 3) && !$past(alarm, 3) && $past(link_synced, 3);
	endproperty
	a_ready: assert property (p_ready) else $error("ready too early");
	property p_mfr;
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[7] |=> wb_ack_o && wb_dat_o == 32'h0;
	endproperty
	a_mfr: assert property (p_mfr) else $error("upper area visible");
	property p_brk;
		$changed(brake_release_output_reg) |-> $past(wb_ack_o) && $past(wb_we_i) && $past(wb_adr_i) == 8'h00;
	endproperty
	a_brk: assert property (p_brk) else $error("brake output moved alone");
	property p_prot;
		protect_active_reg |=> protect_active_reg;
	endproperty
	a_prot: assert property (p_prot) else $error("protection dropped");
	property p_travel;
		travel_stop_reg |-> protect_active_reg;
	endproperty
	a_travel: assert property (p_travel) else $error("travel stop too early");
	property p_on;
		$rose(motor_energized_reg) |-> !$past(dyn_brake_engaged_reg, 8) && !dyn_brake_engaged_reg;
	endproperty
	a_on: assert property (p_on) else $error("energized before brake release");
	property p_off;
		$rose(dyn_brake_engaged_reg) && motor_speed < 16'h001e |-> !motor_energized_reg;
	endproperty
	a_off: assert property (p_off) else $error("brake engaged while energized");
	property p_speed;
		$fell(dyn_brake_engaged_reg) && !motor_energized_reg |-> $past(motor_speed) < 16'h001e;
	endproperty
	a_speed: assert property (p_speed) else $error("servo-on at speed");
endmodule // sebs_chk
bind sebs_sequencer sebs_chk sebs_chk_i (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .init_done, .main_power_ok, .alarm, .link_synced, .motor_speed, .servo_ready_reg,
	.protect_active_reg, .travel_stop_reg, .dyn_brake_engaged_reg, .motor_energized_reg, .brake_release_output_reg);
`default_nettype wire

// [test/servo_enable_brake_sequencer_tb.sv]
// Purpose: self-checking bench of the servo enable and brake sequencer
// Assumes: MS_CYCLES of 10, so one ms is ten cycles
// Notes: the host model owns the register bus
`timescale 1ns/1ps
`default_nettype none
module servo_enable_brake_sequencer_tb;
	localparam int MS = 10;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic init_done = 1'b0, main_power_ok = 1'b0, alarm = 1'b0, link_synced = 1'b0;
	logic positive_travel_inhibit = 1'b0, negative_travel_inhibit = 1'b0;
	logic [15:0] motor_speed = 16'h0000;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic servo_ready_reg, protect_active_reg, travel_stop_reg;
	logic dyn_brake_engaged_reg, motor_energized_reg, brake_release_output_reg;
	int num_errors = 0, comparisons = 0, cyc_cnt = 0;
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) cyc_cnt <= reset ? 0 : cyc_cnt + 1;
	sebs_sequencer #(.MS_CYCLES(MS)) sebs_sequencer_i (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .init_done, .main_power_ok, .alarm,
		.link_synced, .positive_travel_inhibit, .negative_travel_inhibit, .motor_speed, .servo_ready_reg,
		.protect_active_reg, .travel_stop_reg, .dyn_brake_engaged_reg, .motor_energized_reg,
		.brake_release_output_reg);
	sebs_host_model sebs_host_model_i (.mclk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sebs_host_model_i.xfer(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		sebs_host_model_i.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic t_regs;
		rdc(8'h04, 32'h0000_05dc);
		wr(8'h84, 32'hffff_ffff);
		rdc(8'h84, 32'h0);
		chkb(protect_active_reg, 1'b0);
	endtask
	task automatic t_ready;
		chkb(servo_ready_reg, 1'b1);
		link_synced <= 1'b0;
		cy(4);
		chkb(servo_ready_reg, 1'b0);
		link_synced <= 1'b1;
		cy(4);
	endtask
	task automatic t_prot;
		while (cyc_cnt < 1490 * MS) cy(1);
		chkb(travel_stop_reg, 1'b0);
		while (cyc_cnt < 1512 * MS) cy(1);
		chkb(protect_active_reg, 1'b1);
		chkb(travel_stop_reg, 1'b1);
		{positive_travel_inhibit, negative_travel_inhibit} <= 2'b01;
		cy(4);
		chkb(travel_stop_reg, 1'b1);
	endtask
	task automatic t_brake;
		wr(8'h00, 32'h2);
		chkb(brake_release_output_reg, 1'b1);
		chkb(motor_energized_reg, 1'b0);
		wr(8'h00, 32'h0);
		chkb(brake_release_output_reg, 1'b0);
	endtask
	task automatic t_on;
		motor_speed <= 16'h001e;
		chkb(servo_ready_reg, 1'b1);
		wr(8'h00, 32'h1);
		cy(5 * MS);
		chkb(dyn_brake_engaged_reg, 1'b1);
		motor_speed <= 16'h001d;
		cy(3);
		chkb(dyn_brake_engaged_reg, 1'b0);
		cy(MS - 5);
		chkb(motor_energized_reg, 1'b0);
		cy(2 * MS);
		chkb(motor_energized_reg, 1'b1);
	endtask
	task automatic t_stall_off;
		motor_speed <= 16'h0000;
		wr(8'h08, 32'h3);
		wr(8'h00, 32'h0);
		cy(MS);
		chkb(motor_energized_reg, 1'b1);
		cy(5 * MS);
		chkb(motor_energized_reg, 1'b0);
		chkb(dyn_brake_engaged_reg, 1'b1);
	endtask
	task automatic t_run_off;
		wr(8'h00, 32'h1);
		wr(8'h0c, 32'h64);
		wr(8'h14, 32'h2);
		cy(4 * MS);
		motor_speed <= 16'h01f4;
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		cy(2 * MS);
		rdc(8'h18, 32'h0000_0427);
		motor_speed <= 16'h0014;
		cy(5);
		chkb(motor_energized_reg, 1'b0);
		cy(4 * MS);
		chkb(motor_energized_reg, 1'b1);
	endtask
	task automatic t_alarm;
		wr(8'h14, 32'h4);
		motor_speed <= 16'h01f4;
		alarm <= 1'b1;
		cy(4);
		chkb(dyn_brake_engaged_reg, 1'b1);
		chkb(motor_energized_reg, 1'b0);
		chkb(servo_ready_reg, 1'b0);
		motor_speed <= 16'h0000;
		alarm <= 1'b0;
		cy(3 * MS);
		chkb(motor_energized_reg, 1'b1);
		motor_speed <= 16'h01f4;
		wr(8'h14, 32'h1);
		wr(8'h00, 32'h0);
		cy(3);
		chkb(dyn_brake_engaged_reg, 1'b1);
		chkb(motor_energized_reg, 1'b0);
		cy(110 * MS);
		rdc(8'h18, 32'h0000_052b);
		motor_speed <= 16'h0000;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		final_report;
	end
	initial begin
		cy(5);
		reset <= 1'b0;
		{init_done, main_power_ok, link_synced, positive_travel_inhibit} <= 4'hf;
		t_regs;
		t_ready;
		t_prot;
		t_brake;
		t_on;
		t_stall_off;
		t_run_off;
		t_alarm;
		final_report;
	end
endmodule // servo_enable_brake_sequencer_tb
`default_nettype wire
